// ### verilog/sph_pkg.sv
/*
  shared types, field layouts and constants of the speech-parameter frame host controller.
  assumes a single 125 MHz clock domain shared with the codec datapath.
*/
package sph_pkg;

  // ----------------------------------------------------------------
  // codec modes (three-bit mode code, lowest four rates only)
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SPH_MODE_475 = 3'h0,
    SPH_MODE_515 = 3'h1,
    SPH_MODE_590 = 3'h2,
    SPH_MODE_670 = 3'h3
  } sph_mode_t;

  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam int SPH_MAX_FIELDS = 35;
  localparam int SPH_FIELD_W = 9;
  localparam int SPH_IDX_W = 6;
  localparam int SPH_BIT_W = 4;
  localparam logic [SPH_IDX_W-1:0] SPH_LSF_FIELDS = 6'h03;
  localparam logic [SPH_IDX_W-1:0] SPH_FIELDS_475 = 6'h1d;
  localparam logic [SPH_IDX_W-1:0] SPH_FIELDS_515 = 6'h1f;
  localparam logic [SPH_IDX_W-1:0] SPH_FIELDS_590 = 6'h1b;
  localparam logic [SPH_IDX_W-1:0] SPH_FIELDS_670 = 6'h23;
  // fields up to the end of subframe 1
  localparam logic [SPH_IDX_W-1:0] SPH_HEAD_475 = 6'h0a;
  localparam logic [SPH_IDX_W-1:0] SPH_HEAD_515 = 6'h0a;
  localparam logic [SPH_IDX_W-1:0] SPH_HEAD_590 = 6'h09;
  localparam logic [SPH_IDX_W-1:0] SPH_HEAD_670 = 6'h0b;
  localparam logic [7:0] SPH_BITS_475 = 8'h5f;
  localparam logic [7:0] SPH_BITS_515 = 8'h67;
  localparam logic [7:0] SPH_BITS_590 = 8'h76;
  localparam logic [7:0] SPH_BITS_670 = 8'h86;

  // ----------------------------------------------------------------
  // encoder homing frame and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] SPH_FRAME_SAMPLES = 8'ha0;
  localparam logic [15:0] SPH_HOME_WORD = 16'h0008;
  localparam int SPH_CLK_PERIOD_NS = 8;
  localparam int SPH_SAMPLE_NS = 125000;
  localparam int SPH_FRAME_MS = 20;
  localparam int SPH_SAMPLE_CYCLES = SPH_SAMPLE_NS / SPH_CLK_PERIOD_NS;
  localparam sph_mode_t SPH_MODE_RST = SPH_MODE_475;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef logic [SPH_MAX_FIELDS-1:0][SPH_FIELD_W-1:0] sph_fields_t;

  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic data;
  } sph_bit_t;

  typedef struct packed {
    logic valid;
    logic first;
    logic [15:0] word;
  } sph_pcm_t;

  function automatic logic [SPH_IDX_W-1:0] sph_field_count(sph_mode_t m);
    logic [SPH_IDX_W-1:0] n;
    n = SPH_FIELDS_475;
    case (m)
      SPH_MODE_515: n = SPH_FIELDS_515;
      SPH_MODE_590: n = SPH_FIELDS_590;
      SPH_MODE_670: n = SPH_FIELDS_670;
      default: n = SPH_FIELDS_475;
    endcase
    return n;
  endfunction : sph_field_count

  function automatic logic [SPH_IDX_W-1:0] sph_head_count(sph_mode_t m);
    logic [SPH_IDX_W-1:0] n;
    n = SPH_HEAD_475;
    case (m)
      SPH_MODE_515: n = SPH_HEAD_515;
      SPH_MODE_590: n = SPH_HEAD_590;
      SPH_MODE_670: n = SPH_HEAD_670;
      default: n = SPH_HEAD_475;
    endcase
    return n;
  endfunction : sph_head_count

  // width of field i; zero past the end of the frame
  function automatic logic [SPH_BIT_W-1:0] sph_field_width(sph_mode_t m,
                                                         logic [SPH_IDX_W-1:0] i);
    logic [SPH_IDX_W-1:0] j;
    logic [SPH_IDX_W-1:0] k;
    logic [SPH_IDX_W-1:0] q;
    logic [SPH_BIT_W-1:0] w;
    logic narrow_lsf;
    j = i - SPH_LSF_FIELDS;
    k = 6'h00;
    q = 6'h00;
    w = 4'h0;
    narrow_lsf = (m == SPH_MODE_475) || (m == SPH_MODE_515);
    if (i >= sph_field_count(m))
      w = 4'h0;
    else if (i == 6'h00)
      w = 4'h8;
    else if (i < SPH_LSF_FIELDS)
      w = narrow_lsf ? ((i == 6'h01) ? 4'h8 : 4'h7) : 4'h9;
    else
    begin
      case (m)
        SPH_MODE_670:
        begin
          q = j >> 3;
          k = j & 6'h07;
          case (k)
            6'h00: w = 4'h8;
            6'h01, 6'h02: w = 4'h4;
            6'h03: w = 4'h3;
            6'h07: w = 4'h7;
            default: w = 4'h1;
          endcase
          if (k == 6'h00 && q[0]) w = 4'h4;
        end
        SPH_MODE_590:
        begin
          q = j / 6'h06;
          k = j - 6'(q * 6'h06);
          case (k)
            6'h00: w = 4'h8;
            6'h01: w = 4'h5;
            6'h02: w = 4'h4;
            6'h05: w = 4'h6;
            default: w = 4'h1;
          endcase
          if (k == 6'h00 && q[0]) w = 4'h4;
        end
        default:
        begin
          if (m == SPH_MODE_515)
          begin
            q = j / 6'h07;
            k = j - 6'(q * 6'h07);
          end
          else if (j < 6'h07)
            k = j;
          else if (j < 6'h0d)
          begin
            q = 6'h01;
            k = j - 6'h07;
          end
          else if (j < 6'h14)
          begin
            q = 6'h02;
            k = j - 6'h0d;
          end
          else
          begin
            q = 6'h03;
            k = j - 6'h14;
          end
          case (k)
            6'h00: w = (q == 6'h00) ? 4'h8 : 4'h4;
            6'h02, 6'h03: w = 4'h3;
            6'h06: w = (m == SPH_MODE_515) ? 4'h6 : 4'h8;
            default: w = 4'h1;
          endcase
        end
      endcase
    end
    return w;
  endfunction : sph_field_width

endpackage : sph_pkg

// ### verilog/sph_field_seq.sv
/*
  walks the fields of one parameter frame, most significant bit first.
  assumes start_i only while idle and a stable mode during a frame.
*/
`timescale 1ns/100ps
module sph_field_seq
  import sph_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire sph_mode_t mode_i,
  input wire logic start_i,
  input wire logic step_i,
  output logic [SPH_IDX_W-1:0] idx_o,
  output logic [SPH_BIT_W-1:0] bit_o,
  output logic last_o,
  output logic busy_o
);

  logic [SPH_IDX_W-1:0] idx_r, idx_nxt;
  logic [SPH_BIT_W-1:0] bit_r, bit_nxt;
  logic busy_r, busy_nxt;
  logic [SPH_IDX_W-1:0] idx_inc;

  assign idx_inc = idx_r + 6'h01;
  assign last_o = busy_r && (bit_r == 4'h0) && (idx_inc == sph_field_count(mode_i));

  always_comb
  begin
    idx_nxt = idx_r;
    bit_nxt = bit_r;
    busy_nxt = busy_r;
    if (start_i)
    begin
      idx_nxt = 6'h00;
      bit_nxt = sph_field_width(mode_i, 6'h00) - 4'h1;
      busy_nxt = 1'b1;
    end
    else if (busy_r && step_i)
    begin
      if (bit_r != 4'h0)
        bit_nxt = bit_r - 4'h1;
      else if (last_o)
        busy_nxt = 1'b0;
      else
      begin
        idx_nxt = idx_inc;
        bit_nxt = sph_field_width(mode_i, idx_inc) - 4'h1;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      idx_r <= 6'h00;
      bit_r <= 4'h0;
      busy_r <= 1'b0;
    end
    else if (ce_i)
    begin
      idx_r <= idx_nxt;
      bit_r <= bit_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign idx_o = idx_r;
  assign bit_o = bit_r;
  assign busy_o = busy_r;

endmodule : sph_field_seq

// ### verilog/sph_host_ctrl.sv
/*
  host controller facing a low-rate speech codec: sets the mode at reset, serialises
  parameter frames to the decoder, collects parameter frames from the encoder, and
  feeds the encoder pcm with in-band encoder homing frames on request.
  assumes the codec runs on clock_i and takes one bit per cycle while a frame is sent.
*/
`timescale 1ns/100ps
module sph_host_ctrl
  import sph_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SPH_SAMPLE_CYCLES
)
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire sph_mode_t mode_sel_i,
  output sph_mode_t enc_mode_o,
  output sph_mode_t dec_mode_o,
  output logic codec_rst_o,
  input wire sph_fields_t ref_fields_i,
  input wire logic tx_start_i,
  input wire logic tx_test_first_i,
  input wire sph_fields_t tx_fields_i,
  output logic tx_ready_o,
  output logic tx_guard_flip_o,
  output sph_bit_t dec_bit_o,
  input wire sph_bit_t enc_bit_i,
  output sph_fields_t rx_fields_o,
  output logic rx_done_o,
  output logic rx_home_o,
  input wire logic home_req_i,
  input wire logic [15:0] pcm_user_i,
  output logic home_pend_o,
  output sph_pcm_t enc_pcm_o
);

  // ----------------------------------------------------------------
  // mode and codec reset
  // ----------------------------------------------------------------
  sph_mode_t mode_r, mode_nxt;
  logic codec_rst_r;

  // the mode is sampled while reset is held, so the codec never sees a mode change mid-run
  assign mode_nxt = rst_i ? mode_sel_i : mode_r;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      codec_rst_r <= 1'b1;
    else if (ce_i)
      codec_rst_r <= 1'b0;
    if (rst_i || ce_i)
      mode_r <= mode_nxt;
  end

  assign enc_mode_o = mode_r;
  assign dec_mode_o = mode_r;
  assign codec_rst_o = codec_rst_r;

  // ----------------------------------------------------------------
  // per-field compare against the active mode's decoder homing frame
  // ----------------------------------------------------------------
  sph_fields_t tx_fields_r, tx_fields_nxt;
  sph_fields_t rx_work_r, rx_work_nxt;
  logic [SPH_MAX_FIELDS-1:0] head_eq, full_eq;
  logic [SPH_IDX_W-1:0] head_n;

  assign head_n = sph_head_count(mode_r);

  generate
    for (genvar g = 0; g < SPH_MAX_FIELDS; g++)
    begin : g_cmp
      localparam logic [SPH_IDX_W-1:0] GI = SPH_IDX_W'(g);
      // fields outside the compared span count as equal
      assign head_eq[g] = (GI >= head_n) || (tx_fields_i[g] == ref_fields_i[g]);
      assign full_eq[g] = (GI >= sph_field_count(mode_r)) ||
                          (rx_work_nxt[g] == ref_fields_i[g]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // transmit side: fields to the decoder
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPH_TX_IDLE = 2'b01,
    SPH_TX_SEND = 2'b10
  } sph_tx_state_t;

  sph_tx_state_t tx_state_r, tx_state_nxt;
  sph_bit_t dec_bit_r, dec_bit_nxt;
  logic guard_r, guard_nxt;
  logic tx_first_r, tx_first_nxt;
  logic tx_go;
  logic [SPH_IDX_W-1:0] tx_idx;
  logic [SPH_BIT_W-1:0] tx_bit;
  logic tx_last, tx_busy;

  assign tx_ready_o = (tx_state_r == SPH_TX_IDLE);
  assign tx_go = tx_ready_o && tx_start_i;

  sph_field_seq u_tx_seq (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .mode_i(mode_r),
    .start_i(tx_go),
    .step_i(1'b1),
    .idx_o(tx_idx),
    .bit_o(tx_bit),
    .last_o(tx_last),
    .busy_o(tx_busy)
  );

  always_comb
  begin
    tx_state_nxt = tx_state_r;
    tx_fields_nxt = tx_fields_r;
    guard_nxt = guard_r;
    tx_first_nxt = 1'b0;
    dec_bit_nxt = '0;
    unique case (tx_state_r)
      SPH_TX_IDLE:
      begin
        if (tx_go)
        begin
          tx_state_nxt = SPH_TX_SEND;
          tx_fields_nxt = tx_fields_i;
          tx_first_nxt = 1'b1;
          guard_nxt = tx_test_first_i && (&head_eq);
          // a test run must not open with the homing frame: flip the last head bit
          if (guard_nxt)
            tx_fields_nxt[head_n - 6'h01][0] = ~tx_fields_i[head_n - 6'h01][0];
        end
      end
      SPH_TX_SEND:
      begin
        dec_bit_nxt.valid = tx_busy;
        dec_bit_nxt.first = tx_first_r;
        dec_bit_nxt.last = tx_last;
        dec_bit_nxt.data = tx_fields_r[tx_idx][tx_bit];
        if (tx_last)
          tx_state_nxt = SPH_TX_IDLE;
      end
      default: tx_state_nxt = SPH_TX_IDLE;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      tx_state_r <= SPH_TX_IDLE;
      tx_fields_r <= '0;
      guard_r <= 1'b0;
      tx_first_r <= 1'b0;
      dec_bit_r <= '0;
    end
    else if (ce_i)
    begin
      tx_state_r <= tx_state_nxt;
      tx_fields_r <= tx_fields_nxt;
      guard_r <= guard_nxt;
      tx_first_r <= tx_first_nxt;
      dec_bit_r <= dec_bit_nxt;
    end
  end

  assign dec_bit_o = dec_bit_r;
  assign tx_guard_flip_o = guard_r;

  // ----------------------------------------------------------------
  // receive side: fields from the encoder
  // ----------------------------------------------------------------
  sph_bit_t rx_q_r;
  sph_fields_t rx_fields_r, rx_fields_nxt;
  logic rx_done_r, rx_done_nxt;
  logic rx_home_r, rx_home_nxt;
  logic [SPH_IDX_W-1:0] rx_idx;
  logic [SPH_BIT_W-1:0] rx_bit;
  logic rx_last, rx_busy;

  // one stage of delay lets the walker be positioned on field 0 when the first bit lands
  sph_field_seq u_rx_seq (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .mode_i(mode_r),
    .start_i(enc_bit_i.valid && enc_bit_i.first),
    .step_i(rx_q_r.valid),
    .idx_o(rx_idx),
    .bit_o(rx_bit),
    .last_o(rx_last),
    .busy_o(rx_busy)
  );

  always_comb
  begin
    rx_work_nxt = rx_work_r;
    rx_fields_nxt = rx_fields_r;
    rx_done_nxt = 1'b0;
    rx_home_nxt = rx_home_r;
    if (rx_busy && rx_q_r.valid)
    begin
      rx_work_nxt[rx_idx][rx_bit] = rx_q_r.data;
      if (rx_last)
      begin
        rx_fields_nxt = rx_work_nxt;
        rx_done_nxt = 1'b1;
        // matches the active mode's decoder homing frame: the encoder's homing answer
        rx_home_nxt = &full_eq;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rx_q_r <= '0;
      rx_work_r <= '0;
      rx_fields_r <= '0;
      rx_done_r <= 1'b0;
      rx_home_r <= 1'b0;
    end
    else if (ce_i)
    begin
      rx_q_r <= enc_bit_i;
      rx_work_r <= rx_work_nxt;
      rx_fields_r <= rx_fields_nxt;
      rx_done_r <= rx_done_nxt;
      rx_home_r <= rx_home_nxt;
    end
  end

  assign rx_fields_o = rx_fields_r;
  assign rx_done_o = rx_done_r;
  assign rx_home_o = rx_home_r;

  // ----------------------------------------------------------------
  // pcm to the encoder, with aligned encoder homing frames
  // ----------------------------------------------------------------
  localparam int TICK_W = $clog2(SAMPLE_CYCLES + 1);

  logic [TICK_W-1:0] tick_r, tick_nxt;
  logic [7:0] samp_r, samp_nxt;
  logic pend_r, pend_nxt;
  logic homing_r, homing_nxt;
  sph_pcm_t pcm_r, pcm_nxt;
  logic tick;
  logic frame_start;

  assign tick = (tick_r == TICK_W'(SAMPLE_CYCLES - 1));
  assign frame_start = tick && (samp_r == 8'h00);

  always_comb
  begin
    tick_nxt = tick ? '0 : tick_r + TICK_W'(1);
    samp_nxt = samp_r;
    pend_nxt = pend_r || home_req_i;
    homing_nxt = homing_r;
    pcm_nxt = '0;
    if (tick)
    begin
      samp_nxt = (samp_r == SPH_FRAME_SAMPLES - 8'h01) ? 8'h00 : samp_r + 8'h01;
      // a homing frame starts only on a frame boundary, else the encoder ignores it
      if (frame_start)
      begin
        homing_nxt = pend_r;
        pend_nxt = home_req_i;
      end
      pcm_nxt.valid = 1'b1;
      pcm_nxt.first = (samp_r == 8'h00);
      pcm_nxt.word = (frame_start ? pend_r : homing_r) ? SPH_HOME_WORD : pcm_user_i;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      tick_r <= '0;
      samp_r <= 8'h00;
      pend_r <= 1'b0;
      homing_r <= 1'b0;
      pcm_r <= '0;
    end
    else if (ce_i)
    begin
      tick_r <= tick_nxt;
      samp_r <= samp_nxt;
      pend_r <= pend_nxt;
      homing_r <= homing_nxt;
      pcm_r <= pcm_nxt;
    end
  end

  assign home_pend_o = pend_r;
  assign enc_pcm_o = pcm_r;

endmodule : sph_host_ctrl

// ### sim/sph_host_checker.sv
/*
  concurrent checks on the ports of the speech-parameter host controller.
  assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module sph_host_checker
  import sph_pkg::*;
#(
  parameter int SAMPLE_CYCLES = 4
)
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire sph_mode_t mode_sel_i,
  input wire sph_mode_t enc_mode_o,
  input wire sph_mode_t dec_mode_o,
  input wire logic codec_rst_o,
  input wire logic tx_start_i,
  input wire logic tx_test_first_i,
  input wire logic tx_ready_o,
  input wire logic tx_guard_flip_o,
  input wire sph_bit_t dec_bit_o,
  input wire sph_bit_t enc_bit_i,
  input wire logic rx_done_o,
  input wire logic home_pend_o,
  input wire sph_pcm_t enc_pcm_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // bit counters of both serial streams
  // ----------------------------------------------------------------
  logic [7:0] bits, dc_r, dc_nxt, rc_r, rc_nxt;

  always_comb
  begin
    case (dec_mode_o)
      SPH_MODE_515: bits = SPH_BITS_515;
      SPH_MODE_590: bits = SPH_BITS_590;
      SPH_MODE_670: bits = SPH_BITS_670;
      default: bits = SPH_BITS_475;
    endcase
    dc_nxt = dec_bit_o.first ? 8'h01 : dc_r + 8'h01;
    rc_nxt = enc_bit_i.first ? 8'h01 : rc_r + 8'h01;
  end

  always_ff @(posedge clock_i)
  begin
    if (ce_i && dec_bit_o.valid) dc_r <= dc_nxt;
    if (ce_i && enc_bit_i.valid) rc_r <= rc_nxt;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_mode_pair: assert property (enc_mode_o == dec_mode_o)
    else $error("encoder and decoder modes differ");
  a_reset_mode: assert property ($past(rst_i) |-> codec_rst_o && enc_mode_o == $past(mode_sel_i))
    else $error("mode or codec reset wrong after release");
  a_codec_release: assert property (!$past(rst_i) && $past(ce_i) |-> !codec_rst_o)
    else $error("codec reset still high after release");
  a_start_lat: assert property (ce_i && tx_start_i && tx_ready_o |=> !tx_ready_o ##1 (dec_bit_o.valid && dec_bit_o.first))
    else $error("frame start latency wrong");
  a_frame_len: assert property (dec_bit_o.valid && dec_bit_o.last |-> dc_nxt == bits)
    else $error("frame length wrong for mode");
  a_stream_gapless: assert property (dec_bit_o.valid && !dec_bit_o.last |=> dec_bit_o.valid)
    else $error("gap inside transmitted frame");
  a_ready_back: assert property (dec_bit_o.valid && dec_bit_o.last |=> tx_ready_o && !dec_bit_o.valid)
    else $error("transmitter not idle after last bit");
  a_rx_done_lat: assert property (ce_i && enc_bit_i.valid && rc_nxt == bits |-> ##2 rx_done_o)
    else $error("receive done missing");
  a_home_word: assert property ($fell(home_pend_o) |-> ##[0:2] (enc_pcm_o.valid && enc_pcm_o.first && enc_pcm_o.word == SPH_HOME_WORD))
    else $error("homing frame not started at boundary");
  a_guard_src: assert property ($rose(tx_guard_flip_o) |-> $past(tx_start_i && tx_test_first_i))
    else $error("guard flip without test-first request");
endmodule : sph_host_checker

// ### sim/sph_codec_model.sv
/*
  behavioural codec stand-in in loop-back: each decoder frame is played back as the
  encoder stream, optionally with idle cycles between bits.
  assumes the bench waits for the looped frame before it sends the next one.
*/
`timescale 1ns/100ps
module sph_codec_model
  import sph_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire sph_bit_t dec_bit_i,
  input wire logic slow_i,
  output sph_bit_t enc_bit_o
);
  logic [0:255] buf_r;
  logic [7:0] n_r, p_r;
  logic play_r, hold_r;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      play_r <= 1'b0;
      hold_r <= 1'b0;
      enc_bit_o <= '0;
    end
    else
    begin
      if (dec_bit_i.valid)
      begin
        buf_r[dec_bit_i.first ? 8'h00 : n_r] <= dec_bit_i.data;
        n_r <= dec_bit_i.first ? 8'h01 : n_r + 8'h01;
        if (dec_bit_i.last)
        begin
          play_r <= 1'b1;
          p_r <= 8'h00;
        end
      end
      // slow mode stalls every other cycle, like a rate-adapted channel
      hold_r <= slow_i && !hold_r;
      if (play_r && !hold_r)
      begin
        enc_bit_o <= '{1'b1, p_r == 8'h00, p_r == n_r - 8'h01, buf_r[p_r]};
        p_r <= p_r + 8'h01;
        if (p_r == n_r - 8'h01) play_r <= 1'b0;
      end
      else
        enc_bit_o <= '{1'b0, 1'b0, 1'b0, ~enc_bit_o.data};
    end
  end
endmodule : sph_codec_model

// ### sim/speech_param_frame_homing_bench.sv
/*
  self-checking bench: frames of every mode loop through the codec stand-in,
  then reset, guard and homing cases.
  assumes the checker and the codec model are compiled before this file.
*/
`timescale 1ns/100ps
module speech_param_frame_homing_bench
  import sph_pkg::*;
;
  typedef struct packed {sph_mode_t m; logic [8:0] seed; logic home; logic slow;} sph_row_t;
  // mode, field seed, expected home flag, far side stalls
  sph_row_t rows [6] = '{'{SPH_MODE_670, 9'h1a5, 1'b1, 1'b0}, '{SPH_MODE_590, 9'h033, 1'b0, 1'b1},
    '{SPH_MODE_515, 9'h0f1, 1'b1, 1'b1}, '{SPH_MODE_475, 9'h14e, 1'b0, 1'b0},
    '{SPH_MODE_475, 9'h07a, 1'b1, 1'b1}, '{SPH_MODE_670, 9'h1c9, 1'b0, 1'b1}};
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  sph_mode_t mode_sel = SPH_MODE_475;
  sph_fields_t ref_fields = '0;
  sph_fields_t tx_fields = '0;
  logic tx_start = 1'b0, tx_test_first = 1'b0, home_req = 1'b0, slow = 1'b0;
  logic [15:0] pcm_user = 16'h1234;
  sph_mode_t enc_mode, dec_mode;
  logic codec_rst, tx_ready, guard, rx_done, rx_home, home_pend;
  sph_bit_t dec_bit, enc_bit;
  sph_fields_t rx_fields, f, rf;
  sph_pcm_t enc_pcm;
  int n_mismatch = 0;
  int samples_checked = 0;
  int k, s;

  always #4 clock_i = ~clock_i;

  sph_host_ctrl #(.SAMPLE_CYCLES(4)) sph_host_ctrl_i (.clock_i(clock_i), .rst_i(rst_i),
    .ce_i(ce_i), .mode_sel_i(mode_sel), .enc_mode_o(enc_mode), .dec_mode_o(dec_mode),
    .codec_rst_o(codec_rst), .ref_fields_i(ref_fields), .tx_start_i(tx_start),
    .tx_test_first_i(tx_test_first), .tx_fields_i(tx_fields), .tx_ready_o(tx_ready),
    .tx_guard_flip_o(guard), .dec_bit_o(dec_bit), .enc_bit_i(enc_bit), .rx_fields_o(rx_fields),
    .rx_done_o(rx_done), .rx_home_o(rx_home), .home_req_i(home_req), .pcm_user_i(pcm_user),
    .home_pend_o(home_pend), .enc_pcm_o(enc_pcm));
  sph_codec_model sph_codec_model_i (.clock_i(clock_i), .rst_i(rst_i), .dec_bit_i(dec_bit),
    .slow_i(slow), .enc_bit_o(enc_bit));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic int wid(sph_mode_t m, int i);
    string t;
    case (m)
      SPH_MODE_670: t = "89984431117444311178443111744431117";
      SPH_MODE_590: t = "899854116454116854116454116";
      SPH_MODE_515: t = "8878133116413311641331164133116";
      default: t = "88781331184133114133118413311";
    endcase
    return (i < t.len()) ? int'(t[i] - 8'h30) : 0;
  endfunction : wid

  function automatic sph_fields_t mk(sph_mode_t m, logic [8:0] seed);
    sph_fields_t r;
    r = '0;
    for (int g = 0; wid(m, g) > 0; g++) r[g] = (seed + 9'(g * 53)) & 9'((1 << wid(m, g)) - 1);
    return r;
  endfunction : mk

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic check(input string n, input logic [16:0] exp, input logic [16:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
      n_mismatch++;
    end
  endtask : check

  task automatic tmo(input string n);
    $display("MISMATCH %s expected done seen timeout", n);
    n_mismatch++;
    end_sim();
  endtask : tmo

  task automatic rst_mode(input sph_mode_t m, input int n);
    @(posedge clock_i);
    rst_i <= 1'b1;
    mode_sel <= m;
    repeat (n) @(posedge clock_i);
    rst_i <= 1'b0;
    @(negedge clock_i);
    check("mode", 17'({enc_mode, dec_mode}), 17'({m, m}));
    check("rst_state", 17'(8'hc0), 17'({codec_rst, tx_ready, dec_bit, rx_done, enc_pcm.valid}));
    @(negedge clock_i);
    check("codec_rst", 17'(0), 17'(codec_rst));
  endtask : rst_mode

  task automatic send(input sph_mode_t m, input sph_fields_t d, input sph_fields_t r,
                      input logic tf, input int flip, input logic home);
    int j;
    int t;
    sph_fields_t e;
    e = d;
    if (flip >= 0) e[flip][0] = ~e[flip][0];
    t = 0;
    for (int g = 0; wid(m, g) > 0; g++) t += wid(m, g);
    @(posedge clock_i);
    tx_fields <= d;
    ref_fields <= r;
    tx_start <= 1'b1;
    tx_test_first <= tf;
    @(posedge clock_i);
    tx_start <= 1'b0;
    tx_test_first <= 1'b0;
    @(negedge clock_i);
    check("guard", 17'(flip >= 0), 17'(guard));
    for (j = 0; j < 8 && dec_bit.valid !== 1'b1; j++) @(negedge clock_i);
    if (j == 8) tmo("dec_start");
    j = 0;
    for (int g = 0; wid(m, g) > 0; g++)
      for (int b = wid(m, g) - 1; b >= 0; b--)
      begin
        check("dec_bit", 17'({1'b1, j == 0, j == t - 1, e[g][b]}), 17'(dec_bit));
        j++;
        @(negedge clock_i);
      end
    check("dec_idle", 17'({1'b0, 1'b1}), 17'({dec_bit.valid, tx_ready}));
    for (j = 0; j < 400 && rx_done !== 1'b1; j++) @(negedge clock_i);
    if (j == 400) tmo("rx_done");
    for (int g = 0; wid(m, g) > 0; g++) check("rx_field", 17'(e[g]), 17'(rx_fields[g]));
    check("rx_home", 17'(home), 17'(rx_home));
  endtask : send

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_mode(SPH_MODE_475, 12);
    foreach (rows[r])
    begin
      rst_mode(rows[r].m, 2);
      f = mk(rows[r].m, rows[r].seed);
      rf = f;
      // a difference past subframe 1 shows the whole frame is compared
      if (!rows[r].home) rf[20][0] = ~rf[20][0];
      slow <= rows[r].slow;
      send(rows[r].m, f, rf, 1'b0, -1, rows[r].home);
    end
    rst_mode(SPH_MODE_515, 2);
    f = mk(SPH_MODE_515, 9'h0c3);
    send(SPH_MODE_515, f, f, 1'b1, 9, 1'b0);
    rf = f;
    rf[0][0] = ~rf[0][0];
    send(SPH_MODE_515, f, rf, 1'b1, -1, 1'b0);
    @(posedge clock_i);
    home_req <= 1'b1;
    for (k = 0; k < 20 && home_pend !== 1'b1; k++) @(negedge clock_i);
    if (k == 20) tmo("home_pend");
    // pending stays up while the request is held, so wait for the boundary sample itself
    for (k = 0; k < 900 && !(enc_pcm.valid === 1'b1 && enc_pcm.first === 1'b1); k++)
      @(negedge clock_i);
    if (k == 900) tmo("home_start");
    // request still seen in the first homing frame, so a second one follows
    s = 0;
    for (k = 0; k < 3000 && s < 321; k++)
    begin
      if (enc_pcm.valid === 1'b1)
      begin
        check("pcm", {s % 160 == 0, s < 320 ? 16'h0008 : 16'h1234}, {enc_pcm.first, enc_pcm.word});
        s++;
      end
      @(posedge clock_i);
      if (s > 0) home_req <= 1'b0;
      @(negedge clock_i);
    end
    if (s < 321) tmo("pcm");
    end_sim();
  end
endmodule : speech_param_frame_homing_bench

bind sph_host_ctrl sph_host_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) sph_host_checker_i (
  .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .mode_sel_i(mode_sel_i),
  .enc_mode_o(enc_mode_o), .dec_mode_o(dec_mode_o), .codec_rst_o(codec_rst_o),
  .tx_start_i(tx_start_i), .tx_test_first_i(tx_test_first_i), .tx_ready_o(tx_ready_o),
  .tx_guard_flip_o(tx_guard_flip_o), .dec_bit_o(dec_bit_o), .enc_bit_i(enc_bit_i),
  .rx_done_o(rx_done_o), .home_pend_o(home_pend_o), .enc_pcm_o(enc_pcm_o));
